// *** stg_host_sink.sv ***
// Host-side consumer model for the forwarding descriptor stream
`timescale 1ns/1ps
`default_nettype none

module stg_host_sink
  import stg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic slow,
  input wire logic fwdValid,
  input wire stg_fwd_t fwdData,
  output logic fwdReady,
  output logic [7:0] takenCnt,
  output logic [7:0] discardCnt,
  output stg_fwd_t lastTaken
);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fwdReady <= 1'h0;
      takenCnt <= 8'h00;
      discardCnt <= 8'h00;
      lastTaken <= '0;
    end
    else
    begin
      // Slow mode takes every other cycle to exercise backpressure
      fwdReady <= !stall && !(slow && fwdReady);
      if (fwdValid && fwdReady)
      begin
        takenCnt <= takenCnt + 8'h01;
        lastTaken <= fwdData;
        if (fwdData.viaOverride)
          discardCnt <= discardCnt + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// *** stg_pkg.sv ***
// Shared constants and types for the spanning tree state gate
package stg_pkg;
  localparam int STG_PORTS = 7;
  localparam int STG_PW = 3;
  localparam int STG_AW = 8;
  localparam int STG_DW = 32;
  localparam int STG_MACW = 48;
  localparam int STG_FIFO_DEPTH = 8;

  // Byte offsets; port p control sits at STG_OFS_PORT0 + 4*p
  localparam logic [STG_AW-1:0] STG_OFS_PORT0 = 8'h00;
  localparam logic [STG_AW-1:0] STG_OFS_HOST = 8'h20;
  localparam logic [STG_AW-1:0] STG_OFS_FLUSH = 8'h24;
  localparam logic [STG_AW-1:0] STG_OFS_STATUS = 8'h28;
  localparam logic [STG_AW-1:0] STG_OFS_DROPS = 8'h2c;

  // Port control fields
  localparam int STG_B_TXEN = 0;
  localparam int STG_B_RXEN = 1;
  localparam int STG_B_LRNDIS = 2;
  localparam int STG_B_STATE = 4;
  // Host select fields
  localparam int STG_B_HOSTIDX = 0;
  localparam int STG_B_TAILEN = 3;
  // Flush command fields
  localparam int STG_B_FLPORT = 0;
  localparam int STG_B_FLGO = 8;
  // Status fields
  localparam int STG_B_REFUSED = 0;
  localparam int STG_B_FULL = 1;
  localparam int STG_B_EMPTY = 2;

  typedef enum logic [1:0] {
    STG_ST_DISCARD = 2'b00,
    STG_ST_LEARN = 2'b01,
    STG_ST_FWD = 2'b10,
    STG_ST_OTHER = 2'b11
  } stg_state_t;

  typedef struct packed {
    logic lrnDis;
    logic rxEn;
    logic txEn;
  } stg_ctrl_t;

  // Every port starts in the disabled / discarding state
  localparam stg_ctrl_t STG_CTRL_RST = 3'h4;
  localparam stg_ctrl_t STG_CTRL_DISCARD = 3'h4;
  localparam stg_ctrl_t STG_CTRL_LEARN = 3'h0;
  localparam stg_ctrl_t STG_CTRL_FWD = 3'h3;

  typedef struct packed {
    logic [STG_PORTS-1:0] dstMask;
    logic [STG_PW-1:0] srcPort;
    logic [STG_MACW-1:0] srcMac;
    logic overrideHit;
    logic blockOverride;
    logic rxOk;
  } stg_frame_t;

  typedef struct packed {
    logic [STG_PORTS-1:0] dstMask;
    logic [STG_PW-1:0] srcPort;
    logic viaOverride;
  } stg_fwd_t;

  typedef struct packed {
    logic [STG_PW-1:0] port;
    logic [STG_MACW-1:0] mac;
  } stg_learn_t;
endpackage

// *** stg_port_state_gate.sv ***
// Spanning tree port state gate with its decision FIFO
`timescale 1ns/1ps
`default_nettype none

module stg_fifo
  import stg_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = STG_FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic full,
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULLCNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } stg_fifo_state_t;

  stg_fifo_state_t st_q;
  stg_fifo_state_t st_d;
  logic push;
  logic pop;

  assign full = (st_q.cnt == FULLCNT);
  assign empty = (st_q.cnt == '0);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st_q.mem[st_q.rd];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr] = inData;
      st_d.wr = (st_q.wr == LAST) ? '0 : st_q.wr + 1'b1;
    end
    if (pop)
      st_d.rd = (st_q.rd == LAST) ? '0 : st_q.rd + 1'b1;
    if (push && !pop)
      st_d.cnt = st_q.cnt + 1'b1;
    else if (pop && !push)
      st_d.cnt = st_q.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule

module stg_port_state_gate
  import stg_pkg::*;
#(
  parameter int FIFO_DEPTH = STG_FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [STG_AW-1:0] regAddr,
  input wire logic [STG_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [STG_DW-1:0] regRdData,
  input wire logic inValid,
  input wire stg_frame_t inFrame,
  output logic inReady,
  output logic fwdValid,
  output stg_fwd_t fwdData,
  input wire logic fwdReady,
  output logic learnValid,
  output stg_learn_t learnData,
  output logic flushValid,
  output logic [STG_PW-1:0] flushPort
);
  typedef struct packed {
    stg_ctrl_t [STG_PORTS-1:0] ctrl;
    logic hostEn;
    logic [STG_PW-1:0] hostIdx;
    logic refused;
    logic flushValid;
    logic [STG_PW-1:0] flushPort;
    logic learnValid;
    stg_learn_t learn;
    logic [STG_DW-1:0] drops;
    logic [STG_DW-1:0] rdData;
  } stg_top_state_t;

  stg_top_state_t st_q;
  stg_top_state_t st_d;
  logic [STG_PORTS-1:0] hostMask;
  logic [STG_PORTS-1:0] txMask;
  logic [STG_PORTS-1:0] srcBit;
  logic srcValid;
  logic srcIsHost;
  stg_ctrl_t srcCtrl;
  stg_fwd_t fwdIn;
  logic accept;
  logic fifoInReady;
  logic fifoFull;
  logic fifoEmpty;
  logic portSel;
  logic [STG_PW-1:0] portIdx;
  logic [STG_PW-1:0] flReq;

  function automatic stg_state_t stateOf(stg_ctrl_t c);
    unique case (c)
      STG_CTRL_DISCARD: stateOf = STG_ST_DISCARD;
      STG_CTRL_LEARN: stateOf = STG_ST_LEARN;
      STG_CTRL_FWD: stateOf = STG_ST_FWD;
      default: stateOf = STG_ST_OTHER;
    endcase
  endfunction

  assign srcValid = (inFrame.srcPort < STG_PW'(STG_PORTS));
  assign srcCtrl = srcValid ? st_q.ctrl[inFrame.srcPort] : STG_CTRL_RST;
  assign portSel = (regAddr < STG_OFS_HOST) && (regAddr[1:0] == 2'b00)
    && (regAddr[STG_PW+1:2] < STG_PW'(STG_PORTS));
  assign portIdx = regAddr[STG_PW+1:2];
  assign flReq = regWrData[STG_B_FLPORT +: STG_PW];

  // Forwarding decision per frame
  always_comb
  begin
    hostMask = '0;
    srcBit = '0;
    if (st_q.hostEn)
      hostMask[st_q.hostIdx] = 1'b1;
    if (srcValid)
      srcBit[inFrame.srcPort] = 1'b1;
    for (int i = 0; i < STG_PORTS; i++)
      txMask[i] = st_q.ctrl[i].txEn;
    srcIsHost = srcValid && ((srcBit & hostMask) != '0);
    fwdIn.srcPort = inFrame.srcPort;
    fwdIn.viaOverride = 1'b0;
    if (!srcValid)
      fwdIn.dstMask = '0;
    else if (srcIsHost)
    begin
      fwdIn.dstMask = inFrame.dstMask & ~hostMask
        & (inFrame.blockOverride ? {STG_PORTS{1'b1}} : txMask);
    end
    else if (srcCtrl.rxEn)
    begin
      fwdIn.dstMask = inFrame.dstMask & ~srcBit & (txMask | hostMask);
    end
    else
    begin
      fwdIn.dstMask = inFrame.overrideHit ? (inFrame.dstMask & hostMask)
        : '0;
      fwdIn.viaOverride = inFrame.overrideHit;
    end
  end

  assign inReady = fifoInReady;
  assign accept = inValid && inReady;

  stg_fifo #(
    .WIDTH($bits(stg_fwd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(inValid && (fwdIn.dstMask != '0)),
    .inData(fwdIn),
    .inReady(fifoInReady),
    .outValid(fwdValid),
    .outData(fwdData),
    .outReady(fwdReady),
    .full(fifoFull),
    .empty(fifoEmpty)
  );

  always_comb
  begin
    st_d = st_q;
    st_d.flushValid = 1'b0;
    st_d.learnValid = 1'b0;
    st_d.rdData = '0;
    if (accept && srcValid && !srcIsHost && inFrame.rxOk && !srcCtrl.lrnDis)
    begin
      st_d.learnValid = 1'b1;
      st_d.learn.port = inFrame.srcPort;
      st_d.learn.mac = inFrame.srcMac;
    end
    if (accept && (fwdIn.dstMask == '0))
      st_d.drops = st_q.drops + 1'b1;
    if (regWr)
    begin
      if (portSel)
        st_d.ctrl[portIdx] = regWrData[2:0];
      else if (regAddr == STG_OFS_HOST)
      begin
        st_d.hostIdx = regWrData[STG_B_HOSTIDX +: STG_PW];
        st_d.hostEn = regWrData[STG_B_TAILEN];
      end
      else if (regAddr == STG_OFS_FLUSH && regWrData[STG_B_FLGO])
      begin
        if (flReq < STG_PW'(STG_PORTS) && st_q.ctrl[flReq].lrnDis)
        begin
          st_d.flushValid = 1'b1;
          st_d.flushPort = flReq;
        end
        else
          st_d.refused = 1'b1;
      end
      else if (regAddr == STG_OFS_STATUS && regWrData[STG_B_REFUSED])
        st_d.refused = 1'b0;
    end
    if (regRd)
    begin
      if (portSel)
      begin
        st_d.rdData[2:0] = st_q.ctrl[portIdx];
        st_d.rdData[STG_B_STATE +: 2] = stateOf(st_q.ctrl[portIdx]);
      end
      else if (regAddr == STG_OFS_HOST)
      begin
        st_d.rdData[STG_B_HOSTIDX +: STG_PW] = st_q.hostIdx;
        st_d.rdData[STG_B_TAILEN] = st_q.hostEn;
      end
      else if (regAddr == STG_OFS_STATUS)
      begin
        st_d.rdData[STG_B_REFUSED] = st_q.refused;
        st_d.rdData[STG_B_FULL] = fifoFull;
        st_d.rdData[STG_B_EMPTY] = fifoEmpty;
      end
      else if (regAddr == STG_OFS_DROPS)
        st_d.rdData = st_q.drops;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= '0;
      for (int i = 0; i < STG_PORTS; i++)
      begin
        st_q.ctrl[i] <= STG_CTRL_RST;
      end
    end
    else
      st_q <= st_d;
  end

  assign regRdData = st_q.rdData;
  assign learnValid = st_q.learnValid;
  assign learnData = st_q.learn;
  assign flushValid = st_q.flushValid;
  assign flushPort = st_q.flushPort;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_take_port;
    accept && srcValid && !srcIsHost;
  endsequence

  sequence s_flush_wr;
    regWr && regAddr == STG_OFS_FLUSH && regWrData[STG_B_FLGO]
      && flReq < STG_PW'(STG_PORTS);
  endsequence

  a_host_ignored: assert property (
    accept && srcIsHost |=> !learnValid)
    else $error("host port frame learned");
  a_disabled_drop: assert property (
    s_take_port ##0 (srcCtrl == STG_CTRL_DISCARD && !inFrame.overrideHit)
      |=> st_q.drops == $past(st_q.drops) + 1'b1 && !learnValid)
    else $error("disabled port frame not dropped");
  a_blocking_host: assert property (
    s_take_port ##0 !srcCtrl.rxEn |-> (fwdIn.dstMask & ~hostMask) == '0)
    else $error("blocked port reached a non-host port");
  a_listen_tx: assert property (
    accept && srcIsHost && !inFrame.blockOverride
      |-> (fwdIn.dstMask & ~txMask) == '0)
    else $error("host frame left a port with transmit off");
  a_learn_state: assert property (
    s_take_port ##0 (srcCtrl == STG_CTRL_LEARN && inFrame.rxOk)
      |=> learnValid && learnData.port == $past(inFrame.srcPort))
    else $error("learning state did not learn");
  a_fwd_pass: assert property (
    s_take_port ##0 srcCtrl.rxEn |-> fwdIn.dstMask
      == (inFrame.dstMask & ~srcBit & (txMask | hostMask)))
    else $error("forwarding port mask wrong");
  a_override_host: assert property (
    s_take_port ##0 (!srcCtrl.rxEn && inFrame.overrideHit)
      |-> fwdIn.dstMask == (inFrame.dstMask & hostMask) && fwdIn.viaOverride)
    else $error("override match not sent to host");
  a_host_override: assert property (
    accept && srcIsHost && inFrame.blockOverride
      |-> fwdIn.dstMask == (inFrame.dstMask & ~hostMask))
    else $error("host override frame not sent");
  a_discard_read: assert property (
    regRd && portSel && st_q.ctrl[portIdx] == STG_CTRL_DISCARD
      |=> regRdData[STG_B_STATE +: 2] == STG_ST_DISCARD)
    else $error("discarding state misreported");
  a_flush_ok: assert property (
    s_flush_wr ##0 st_q.ctrl[flReq].lrnDis
      |=> flushValid && flushPort == $past(flReq)
      ##1 (!flushValid || $past(regWr && regAddr == STG_OFS_FLUSH)))
    else $error("flush not issued on learning-off port");
  a_flush_refuse: assert property (
    s_flush_wr ##0 !st_q.ctrl[flReq].lrnDis |=> !flushValid && st_q.refused)
    else $error("flush not refused on learning port");
  a_learn_cause: assert property (
    learnValid |-> $past(accept) && !$past(srcCtrl.lrnDis))
    else $error("learn without cause");
endmodule

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the port state gate
`timescale 1ns/1ps
`default_nettype none

module testbench
  import stg_pkg::*;
;
  typedef struct packed {
    stg_frame_t f;
    logic [6:0] m;
    logic l;
    logic v;
  } stg_row_t;

  logic clk;
  logic nrst;
  logic [STG_AW-1:0] regAddr;
  logic [STG_DW-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [STG_DW-1:0] regRdData;
  logic inValid;
  stg_frame_t inFrame;
  logic inReady;
  logic fwdValid;
  stg_fwd_t fwdData;
  logic fwdReady;
  logic learnValid;
  stg_learn_t learnData;
  logic flushValid;
  logic [STG_PW-1:0] flushPort;
  logic stall;
  logic slow;
  logic [7:0] takenCnt;
  logic [7:0] discardCnt;
  logic [7:0] c;
  stg_fwd_t lastTaken;
  int errorCnt = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  stg_row_t rows [9];

  stg_port_state_gate #(.FIFO_DEPTH(8)) dut (.clk, .nrst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .inValid, .inFrame, .inReady,
    .fwdValid, .fwdData, .fwdReady, .learnValid, .learnData, .flushValid,
    .flushPort);

  stg_host_sink sink (.clk, .nrst, .stall, .slow, .fwdValid, .fwdData,
    .fwdReady, .takenCnt, .discardCnt, .lastTaken);

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errorCnt++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [63:0] seen,
    input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    chk("regRdData", 64'(regRdData), 64'(exp));
  endtask

  task automatic send(input stg_frame_t f);
    logic ok;
    @(posedge clk);
    inValid <= 1'h1;
    inFrame <= f;
    ok = 1'h0;
    for (int i = 0; i < 20 && ok !== 1'h1; i++)
    begin
      @(negedge clk);
      ok = inReady;
      @(posedge clk);
    end
    inValid <= 1'h0;
  endtask

  task automatic wait_cnt(input logic [7:0] target);
    for (int i = 0; i < 40 && takenCnt !== target; i++)
      @(negedge clk);
    chk("takenCnt", 64'(takenCnt), 64'(target));
  endtask

  function automatic stg_row_t mk(input logic [2:0] s, input logic [6:0] d,
    input logic [2:0] obr, input logic [6:0] m, input logic l,
    input logic v);
    return {d, s, 45'h0a0b0c0d0e0, s, obr, m, l, v};
  endfunction

  initial
  begin
    nrst = 1'h0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'h0;
    regRd = 1'h0;
    inValid = 1'h0;
    inFrame = '0;
    stall = 1'h0;
    slow = 1'h0;
    // Ports: 0,1 forwarding, 2 learning, 3 discarding, host is 6
    rows[0] = mk(3'h0, 7'h46, 3'h1, 7'h42, 1'h1, 1'h0);
    rows[1] = mk(3'h1, 7'h02, 3'h0, 7'h00, 1'h0, 1'h0);
    rows[2] = mk(3'h2, 7'h41, 3'h1, 7'h00, 1'h1, 1'h0);
    rows[3] = mk(3'h2, 7'h41, 3'h5, 7'h40, 1'h1, 1'h1);
    rows[4] = mk(3'h3, 7'h41, 3'h5, 7'h40, 1'h0, 1'h1);
    rows[5] = mk(3'h3, 7'h03, 3'h1, 7'h00, 1'h0, 1'h0);
    rows[6] = mk(3'h6, 7'h07, 3'h1, 7'h03, 1'h0, 1'h0);
    // host override only toward the learning port
    rows[7] = mk(3'h6, 7'h04, 3'h3, 7'h04, 1'h0, 1'h0);
    rows[8] = mk(3'h7, 7'h01, 3'h1, 7'h00, 1'h0, 1'h0);
    repeat (16) @(posedge clk);
    chk("rstOut", 64'({regRdData, inReady, fwdValid, learnValid}),
      64'h4);
    nrst <= 1'h1;
    rd(STG_OFS_PORT0, 32'h04);
    wr(STG_OFS_PORT0, 32'h3);
    wr(8'h04, 32'h33);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h4);
    wr(STG_OFS_HOST, 32'he);
    rd(STG_OFS_PORT0, 32'h23);
    rd(8'h04, 32'h23);
    rd(8'h08, 32'h10);
    rd(8'h0c, 32'h04);
    rd(STG_OFS_HOST, 32'h0e);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    foreach (rows[k])
    begin
      c = takenCnt;
      send(rows[k].f);
      @(negedge clk);
      chk("learnValid", 64'(learnValid), 64'(rows[k].l));
      if (rows[k].l)
        chk("learnData", 64'(learnData),
          64'({rows[k].f.srcPort, rows[k].f.srcMac}));
      if (rows[k].m != 7'h0)
      begin
        wait_cnt(c + 8'h01);
        chk("fwdData", 64'(lastTaken),
          64'({rows[k].m, rows[k].f.srcPort, rows[k].v}));
      end
    end
    chk("taken", 64'(takenCnt), 64'h5);
    chk("discard", 64'(discardCnt), 64'h2);
    rd(STG_OFS_DROPS, 32'h4);
    wr(STG_OFS_FLUSH, 32'h103);
    @(negedge clk);
    chk("flush", 64'({flushValid, flushPort}), 64'hb);
    wr(STG_OFS_FLUSH, 32'h100);
    @(negedge clk);
    chk("flushValid", 64'(flushValid), 64'h0);
    rd(STG_OFS_STATUS, 32'h5);
    wr(STG_OFS_STATUS, 32'h1);
    rd(STG_OFS_STATUS, 32'h4);
    // Fill the FIFO while the consumer stalls
    stall <= 1'h1;
    c = takenCnt;
    @(posedge clk);
    inValid <= 1'h1;
    inFrame <= rows[0].f;
    n = 0;
    repeat (12)
    begin
      @(negedge clk);
      if (inReady === 1'h1)
        n++;
      @(posedge clk);
    end
    inValid <= 1'h0;
    chk("accepted", 64'(n), 64'h8);
    rd(STG_OFS_STATUS, 32'h2);
    slow <= 1'h1;
    stall <= 1'h0;
    wait_cnt(c + 8'h08);
    chk("lastTaken", 64'(lastTaken), 64'({7'h42, 3'h0, 1'h0}));
    rd(STG_OFS_STATUS, 32'h4);
    // Second reset in mid-run
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd(STG_OFS_PORT0, 32'h04);
    rd(STG_OFS_DROPS, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
